// ### logic/ipc_map.svh
// register offsets, field positions, reset values and timing counts of the interrupt priority block
`ifndef IPC_MAP_SVH
`define IPC_MAP_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define IPC_ADDR_STATE  8'h00
`define IPC_ADDR_PEND   8'h04
`define IPC_ADDR_TIMER  8'h30
`define IPC_ADDR_CTRL   8'h34
`define IPC_MASK_PAGE   4'h1
`define IPC_STAT_PAGE   4'h2
// ---------------------------------------------------------------
// level bit positions and level masks (bit = level - 1), control register bit positions
// ---------------------------------------------------------------
`define IPC_BIT_MCHK    1
`define IPC_BIT_ETC     16
`define IPC_BIT_CONS    17
`define IPC_P4_LEVELS   32'h0000_0003
`define IPC_UNASSIGNED  32'h000c_0100
`define IPC_NOMASK      32'h0000_0001
`define IPC_CTRL_TIMER  0
`define IPC_CTRL_HALT   1
// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define IPC_MASK_RST    32'h0000_0000
`define IPC_TIMER_RST   32'h0000_0000
`define IPC_TICK_NS     1000000
`define IPC_CLK_NS      50
`define IPC_TICK_CYCLES (`IPC_TICK_NS / `IPC_CLK_NS)
`endif

// ### logic/ipc_pkg.sv
// types of the interrupt priority block
package ipc_pkg;
  typedef enum logic [3:0] {
    ipc_st_p1 = 4'b0001,
    ipc_st_p2 = 4'b0010,
    ipc_st_p3 = 4'b0100,
    ipc_st_p4 = 4'b1000
  } ipc_state_t;
  typedef logic [31:0] ipc_word_t;
endpackage : ipc_pkg

// ### logic/ipc_top.sv
// interrupt priority resolver with parity checking, elapsed-time counter and apb registers
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "ipc_map.svh"
module ipc_top #(
  parameter int unsigned TICK_CYCLES = `IPC_TICK_CYCLES
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             power_fail,
  input  wire logic             equip_fault,
  input  wire logic [5:0]       ext_signal,
  input  wire logic [5:0]       selector_req,
  input  wire logic             mux_req,
  input  wire logic             console_req,
  input  wire logic             start_device_busy,
  input  wire logic             svc_call,
  input  wire logic             priv_op,
  input  wire logic             opcode_trap,
  input  wire logic             address_err,
  input  wire logic             data_err,
  input  wire logic             exp_overflow,
  input  wire logic             divide_err,
  input  wire logic             signif_err,
  input  wire logic             exp_underflow,
  input  wire logic             dec_overflow,
  input  wire logic             fixed_overflow,
  input  wire logic             test_mode,
  input  wire logic             main_memory_valid,
  input  wire logic [32:0]      main_memory_word,
  input  wire logic             peripheral_data_valid,
  input  wire logic [8:0]       peripheral_data_register,
  input  wire logic             fast_register_memory_valid,
  input  wire logic [32:0]      fast_register_memory_word,
  input  wire logic             protect_key_valid,
  input  wire logic [8:0]       protect_key_pair,
  output logic                  int_take,
  output logic [5:0]            int_level,
  output ipc_pkg::ipc_state_t   proc_state,
  output logic                  halt
);
  import ipc_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // data plus its parity bit must hold an odd number of ones
  function automatic logic parity_bad(input logic [32:0] v);
    parity_bad = ~(^v);
  endfunction : parity_bad

  function automatic logic [1:0] state_index(input ipc_state_t s);
    state_index = (s == ipc_st_p4) ? 2'd3 : (s == ipc_st_p3) ? 2'd2 : (s == ipc_st_p2) ? 2'd1 : 2'd0;
  endfunction : state_index

  // lowest set bit is the most urgent level
  function automatic logic [4:0] first_set(input ipc_word_t v);
    first_set = 5'd0;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 5'(i);
      end
    end
  endfunction : first_set

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  ipc_state_t state_reg, state_next;
  ipc_word_t  pend_reg, pend_next;
  ipc_word_t  mask_reg [4];
  ipc_word_t  stat_reg [4];
  ipc_word_t  timer_reg, timer_next;
  logic       timer_en_reg;
  logic [15:0] presc_reg;
  logic       halt_reg, halt_next;
  logic       take_reg;
  logic [5:0] level_reg;
  logic [31:0] rdata_reg;
  logic       ready_reg;
  logic       err_reg;

  // ---------------------------------------------------------------
  // parity checks
  // ---------------------------------------------------------------
  wire logic mm_err  = main_memory_valid & parity_bad(main_memory_word);
  wire logic dr_err  = peripheral_data_valid & parity_bad({24'h000000, peripheral_data_register});
  wire logic fm_err  = fast_register_memory_valid & parity_bad(fast_register_memory_word);
  wire logic key_err = protect_key_valid & parity_bad({24'h000000, protect_key_pair});
  wire logic in_p4   = (state_reg == ipc_st_p4);
  wire logic io_err  = mm_err | dr_err;
  // main or peripheral error interrupts unless already in machine condition state
  wire logic mchk_req = equip_fault | fm_err | (io_err & ~in_p4);
  wire logic stop_req = key_err | (io_err & in_p4);

  // ---------------------------------------------------------------
  // elapsed-time counter
  // ---------------------------------------------------------------
  wire logic tick      = timer_en_reg && (presc_reg == 16'(TICK_CYCLES - 1));
  wire logic etc_expire = tick && (timer_reg == 32'h0000_0001);

  // ---------------------------------------------------------------
  // condition vector, bit n is level n+1
  // ---------------------------------------------------------------
  wire ipc_word_t new_req = {test_mode, fixed_overflow, dec_overflow, exp_underflow,
                             signif_err, divide_err, exp_overflow, data_err,
                             address_err, opcode_trap, priv_op, svc_call, 2'b00,
                             console_req, etc_expire, mux_req, selector_req,
                             1'b0, ext_signal, mchk_req, power_fail};

  // ---------------------------------------------------------------
  // resolution
  // ---------------------------------------------------------------
  wire logic [1:0] cur_idx = state_index(state_reg);
  wire ipc_word_t  hold    = start_device_busy ? (32'h1 << `IPC_BIT_CONS) : 32'h0;
  // program states take all, control state only machine conditions, machine state none
  wire ipc_word_t  cls     = (state_reg == ipc_st_p3) ? `IPC_P4_LEVELS : in_p4 ? 32'h0 : 32'hffff_ffff;
  wire ipc_word_t  elig    = pend_reg & ~hold & cls & (mask_reg[cur_idx] | `IPC_NOMASK);
  wire logic       take_w  = (elig != 32'h0) && !halt_reg;
  wire logic [4:0] lvl_w   = first_set(elig);
  wire ipc_word_t  lvl_bit = take_w ? (32'h1 << lvl_w) : 32'h0;
  wire logic       to_p4   = lvl_w < 5'd2;
  wire ipc_state_t target  = to_p4 ? ipc_st_p4 : ipc_st_p3;
  wire logic [1:0] tgt_idx = state_index(target);

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire logic setup    = psel && !penable;
  wire logic wr_do    = psel && penable && pready && pwrite && !pslverr;
  wire logic hit_mask = paddr[7:4] == `IPC_MASK_PAGE;
  wire logic hit_stat = paddr[7:4] == `IPC_STAT_PAGE;
  wire logic [1:0] ridx = paddr[3:2];
  wire logic hit_any  = (paddr[1:0] == 2'b00) && (hit_mask || hit_stat || paddr == `IPC_ADDR_STATE ||
                        paddr == `IPC_ADDR_PEND || paddr == `IPC_ADDR_TIMER || paddr == `IPC_ADDR_CTRL);
  wire logic wr_state = wr_do && paddr == `IPC_ADDR_STATE;
  wire logic wr_timer = wr_do && paddr == `IPC_ADDR_TIMER;
  wire logic wr_ctrl  = wr_do && paddr == `IPC_ADDR_CTRL;

  // read data selection
  logic [31:0] rdata_w;
  always_comb begin
    if (paddr == `IPC_ADDR_STATE) begin
      rdata_w = {30'h0, cur_idx};
    end else if (paddr == `IPC_ADDR_PEND) begin
      rdata_w = pend_reg;
    end else if (hit_mask) begin
      rdata_w = mask_reg[ridx];
    end else if (hit_stat) begin
      rdata_w = stat_reg[ridx];
    end else if (paddr == `IPC_ADDR_TIMER) begin
      rdata_w = timer_reg;
    end else if (paddr == `IPC_ADDR_CTRL) begin
      rdata_w = {30'h0, halt_reg, timer_en_reg};
    end else begin
      rdata_w = 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  // taken level leaves pending; a new request in the same cycle wins
  assign pend_next  = ((pend_reg & ~lvl_bit) | new_req) & ~`IPC_UNASSIGNED;
  assign state_next = take_w ? target : wr_state ? ipc_state_t'(4'b0001 << pwdata[1:0]) : state_reg;
  assign halt_next  = stop_req | (halt_reg & ~(wr_ctrl & pwdata[`IPC_CTRL_HALT]));
  assign timer_next = wr_timer ? pwdata : (tick && timer_reg != 32'h0) ? timer_reg - 32'h1 : timer_reg;

  // ---------------------------------------------------------------
  // state, pending and halt
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ipc_st_p1;
      pend_reg  <= 32'h0;
      halt_reg  <= 1'b0;
      take_reg  <= 1'b0;
      level_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      pend_reg  <= pend_next;
      halt_reg  <= halt_next;
      take_reg  <= take_w;
      level_reg <= take_w ? {1'b0, lvl_w} + 6'h01 : level_reg;
    end
  end

  // per-state mask and status; status sets on entry and is cleared by writing ones
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        mask_reg[i] <= `IPC_MASK_RST;
        stat_reg[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_do && hit_mask && ridx == 2'(i)) begin
          mask_reg[i] <= pwdata;
        end
        stat_reg[i] <= (stat_reg[i] & ~((wr_do && hit_stat && ridx == 2'(i)) ? pwdata : 32'h0))
                       | ((tgt_idx == 2'(i)) ? lvl_bit : 32'h0);
      end
    end
  end

  // elapsed-time counter and prescaler
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      timer_reg    <= `IPC_TIMER_RST;
      timer_en_reg <= 1'b0;
      presc_reg    <= 16'h0000;
    end else begin
      timer_reg    <= timer_next;
      timer_en_reg <= wr_ctrl ? pwdata[`IPC_CTRL_TIMER] : timer_en_reg;
      presc_reg    <= (!timer_en_reg || tick) ? 16'h0000 : presc_reg + 16'h0001;
    end
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 32'h0;
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      ready_reg <= setup;
      err_reg   <= setup && !hit_any;
      rdata_reg <= (setup && !pwrite && hit_any) ? rdata_w : 32'h0;
    end
  end

  assign prdata     = rdata_reg;
  assign pready     = ready_reg;
  assign pslverr    = err_reg;
  assign int_take   = take_reg;
  assign int_level  = level_reg;
  assign proc_state = state_reg;
  assign halt       = halt_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_take_top_prio: assert property (take_w |-> (elig & ((32'h1 << lvl_w) - 32'h1)) == 32'h0)
    else $error("lower level taken before a more urgent one");
  a_target_state: assert property (int_take |-> (proc_state == ipc_st_p4) == (int_level <= 6'd2))
    else $error("interrupt entered the wrong state");
  a_key_halt: assert property (protect_key_valid && key_err |=> halt && !int_take)
    else $error("protect key parity error did not halt");
  a_p4_stop: assert property (in_p4 && io_err |=> halt)
    else $error("parity error in machine state did not halt");
  a_parity_mchk: assert property (!in_p4 && mm_err |=> pend_reg[`IPC_BIT_MCHK] || int_take)
    else $error("main memory parity error not raised as machine check");
  a_cons_hold: assert property (start_device_busy |-> !(take_w && lvl_w == 5'(`IPC_BIT_CONS)))
    else $error("console request taken during start device");
  a_no_unassigned: assert property ((pend_reg & `IPC_UNASSIGNED) == 32'h0)
    else $error("unassigned level pending");
  a_pend_kept: assert property (!take_w |=> (pend_reg & $past(pend_reg)) == $past(pend_reg))
    else $error("pending condition lost without service");
  a_timer_expire: assert property (etc_expire && !wr_timer |=> pend_reg[`IPC_BIT_ETC] && timer_reg == 32'h0)
    else $error("elapsed-time expiry not raised");
  a_halt_blocks: assert property (halt_reg |-> !take_w)
    else $error("interrupt taken while halted");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not in first access cycle");

  // taken levels stay inside the documented range
  a_level_range: assert property (int_take |-> int_level >= 6'd1 && int_level <= 6'd32)
    else $error("taken level out of range");

  // power failure cannot be masked and goes first outside machine state
  a_power_unmasked: assert property (pend_reg[0] && !halt_reg && !in_p4 |-> take_w && lvl_w == 5'd0)
    else $error("power failure not taken first");

  // machine check enters the machine condition state
  a_mchk_to_p4: assert property (take_w && lvl_w == 5'd1 |=> proc_state == ipc_st_p4)
    else $error("machine check entered the wrong state");

  // every other level from 10 up enters the interrupt control state
  a_chan_to_p3: assert property (take_w && lvl_w >= 5'd9 && lvl_w <= 5'd15 |=> proc_state == ipc_st_p3)
    else $error("channel request entered the wrong state");
  a_etc_to_p3: assert property (take_w && lvl_w == 5'(`IPC_BIT_ETC) |=> proc_state == ipc_st_p3)
    else $error("elapsed-time interrupt entered the wrong state");
  a_cons_to_p3: assert property (take_w && lvl_w == 5'(`IPC_BIT_CONS) |=> proc_state == ipc_st_p3)
    else $error("console interrupt entered the wrong state");
  a_svc_to_p3: assert property (take_w && lvl_w == 5'd20 |=> proc_state == ipc_st_p3)
    else $error("supervisor call entered the wrong state");
  a_opcode_to_p3: assert property (take_w && (lvl_w == 5'd21 || lvl_w == 5'd22) |=> proc_state == ipc_st_p3)
    else $error("op-code or privilege trap entered the wrong state");
  a_addr_to_p3: assert property (take_w && (lvl_w == 5'd23 || lvl_w == 5'd24) |=> proc_state == ipc_st_p3)
    else $error("address or data error entered the wrong state");
  a_expo_to_p3: assert property (take_w && (lvl_w == 5'd25 || lvl_w == 5'd26) |=> proc_state == ipc_st_p3)
    else $error("exponent or divide error entered the wrong state");
  a_signif_to_p3: assert property (take_w && lvl_w == 5'd27 |=> proc_state == ipc_st_p3)
    else $error("significance error entered the wrong state");
  a_under_to_p3: assert property (take_w && lvl_w == 5'd28 |=> proc_state == ipc_st_p3)
    else $error("exponent underflow entered the wrong state");
  a_decov_to_p3: assert property (take_w && lvl_w == 5'd29 |=> proc_state == ipc_st_p3)
    else $error("decimal overflow entered the wrong state");
  a_fixov_to_p3: assert property (take_w && lvl_w >= 5'd30 |=> proc_state == ipc_st_p3)
    else $error("fixed-point or test mode entered the wrong state");

  // parity errors that must not stop the processor raise a machine check
  a_dr_mchk: assert property (!in_p4 && dr_err |=> pend_reg[`IPC_BIT_MCHK] || int_take)
    else $error("peripheral parity error not raised as machine check");
  a_fm_mchk: assert property (fm_err |=> pend_reg[`IPC_BIT_MCHK])
    else $error("fast memory parity error not raised as machine check");

  // a stopped processor stays stopped until software clears it
  a_stop_held: assert property (halt_reg && !wr_ctrl |=> halt_reg)
    else $error("halt dropped without a clear");

  // each tick takes one from a running count
  a_timer_step: assert property (tick && timer_reg != 32'h0 && !wr_timer |=> timer_reg == $past(timer_reg) - 32'h1)
    else $error("elapsed-time count did not step");

  // only levels permitted by the current state's mask, plus power failure, are taken
  a_mask_permit: assert property (take_w |-> ((mask_reg[cur_idx] | `IPC_NOMASK) & lvl_bit) != 32'h0)
    else $error("masked level taken");
  a_p4_no_take: assert property (in_p4 |-> !take_w)
    else $error("interrupt taken in machine condition state");

endmodule : ipc_top

// ### tb/ipc_req_model.sv
// requester model: channels, instruction unit, console and memories
`timescale 1ns/1ps
module ipc_req_model (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        fire,
  input  wire logic [31:0] req_vec,
  input  wire logic [2:0]  par_kind,
  input  wire logic        par_bad,
  output logic [31:0]      cond,
  output logic [3:0]       wvalid,
  output logic [32:0]      word33,
  output logic [8:0]       word9
);
  logic [31:0] hit_reg;
  logic [2:0]  kind_reg;
  logic        bad_reg;
  logic [31:0] pat_reg;
  // one-cycle pulses; idle data lines keep changing so stale values never match
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hit_reg  <= 32'h0;
      kind_reg <= 3'h0;
      bad_reg  <= 1'b0;
      pat_reg  <= 32'h0;
    end else begin
      hit_reg  <= fire ? req_vec : 32'h0;
      kind_reg <= fire ? par_kind : 3'h0;
      bad_reg  <= fire & par_bad;
      pat_reg  <= {pat_reg[30:0], ~pat_reg[31]};
    end
  end
  // bit n of cond is level n+1; parity makes each unit odd unless a bad unit is ordered
  assign cond   = hit_reg;
  assign wvalid = (kind_reg == 3'h0) ? 4'h0 : 4'h1 << (kind_reg - 3'h1);
  assign word33 = {~(^pat_reg) ^ bad_reg, pat_reg};
  assign word9  = {~(^pat_reg[7:0]) ^ bad_reg, pat_reg[7:0]};
endmodule : ipc_req_model

// ### tb/testbench.sv
// self-checking bench for the interrupt priority block
`timescale 1ns/1ps
module testbench;
  import ipc_pkg::*;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] req_vec = 32'h0;
  logic        fire = 1'b0;
  logic        par_bad = 1'b0;
  logic [2:0]  par_kind = 3'h0;
  logic        start_device_busy = 1'b0;
  logic [31:0] prdata, cond, rdat;
  logic        pready, pslverr, int_take, halt, rerr;
  logic [5:0]  int_level;
  ipc_state_t  proc_state;
  logic [3:0]  wvalid;
  logic [32:0] word33;
  logic [8:0]  word9;
  logic [5:0]  lq[$];
  ipc_state_t  sq[$];
  int          err_total = 0;
  int          cmp_count = 0;
  // model lines mapped onto the condition and parity inputs
  ipc_top #(.TICK_CYCLES(4)) dut (.*,
    .power_fail(cond[0]), .equip_fault(cond[1]), .ext_signal(cond[7:2]), .selector_req(cond[14:9]),
    .mux_req(cond[15]), .console_req(cond[17]), .svc_call(cond[20]), .priv_op(cond[21]),
    .opcode_trap(cond[22]), .address_err(cond[23]), .data_err(cond[24]), .exp_overflow(cond[25]),
    .divide_err(cond[26]), .signif_err(cond[27]), .exp_underflow(cond[28]), .dec_overflow(cond[29]),
    .fixed_overflow(cond[30]), .test_mode(cond[31]), .main_memory_valid(wvalid[0]),
    .main_memory_word(word33), .peripheral_data_valid(wvalid[1]), .peripheral_data_register(word9),
    .fast_register_memory_valid(wvalid[2]), .fast_register_memory_word(word33),
    .protect_key_valid(wvalid[3]), .protect_key_pair(word9));
  ipc_req_model model (.*);
  // 20 MHz clock
  always #25 clock = ~clock;
  // record every take with its level and entered state
  always @(posedge clock) begin
    if (int_take === 1'b1) begin
      lq.push_back(int_level);
      sq.push_back(proc_state);
    end
  end
  // report a mismatch
  task automatic fail(input string m);
    err_total++;
    $display("ERROR t=%0t %s", $time, m);
  endtask : fail
  // compare one value
  task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) fail($sformatf("%s %h/%h", m, g, e));
  endtask : ck
  // one apb transfer, released after pready is seen or after 20 access cycles without it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fail("no pready");
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  // register read against an expected value
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    ck(rdat, e, "read");
  endtask : rd
  // drive a request vector or a parity unit for one cycle
  task automatic fr(input logic [31:0] v, input logic [2:0] k, input logic b);
    fire     <= 1'b1;
    req_vec  <= v;
    par_kind <= k;
    par_bad  <= b;
    @(posedge clock);
    fire <= 1'b0;
    @(posedge clock);
  endtask : fr
  // wait for a take, then check its level and entered state
  task automatic tk(input int l);
    int n;
    n = 0;
    while (lq.size() == 0 && n < 60) begin
      @(posedge clock);
      n++;
    end
    if (lq.size() == 0) fail("no take");
    else begin
      ck({26'h0, lq.pop_front()}, l, "level");
      ck({28'h0, sq.pop_front()}, (l <= 2) ? {28'h0, ipc_st_p4} : {28'h0, ipc_st_p3}, "state");
    end
  endtask : tk
  // no take may occur for n cycles
  task automatic nt(input int n);
    repeat (n) @(posedge clock);
    ck(lq.size(), 0, "stray take");
  endtask : nt
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rd(8'h10, 32'h0);
    rd(8'h04, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    ck({31'h0, rerr}, 32'h1, "unmapped");
    apb(1'b1, 8'h10, 32'hffff_ffff);
    for (int i = 1; i <= 32; i++) begin
      if (i == 9 || i == 17 || i == 19 || i == 20) continue;
      fr(32'h1 << (i - 1), 3'h0, 1'b0);
      tk(i);
      apb(1'b1, 8'h00, 32'h0);
    end
    rd(8'h28, 32'hfff2_fefc);
    rd(8'h2c, 32'h0000_0003);
    fr(32'h2000_0200, 3'h0, 1'b0);
    tk(10);
    rd(8'h04, 32'h2000_0000);
    apb(1'b1, 8'h00, 32'h0);
    tk(30);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    fr(32'h0000_0200, 3'h0, 1'b0);
    nt(6);
    rd(8'h04, 32'h0000_0200);
    fr(32'h1, 3'h0, 1'b0);
    tk(1);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h10, 32'h0000_0200);
    tk(10);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    start_device_busy <= 1'b1;
    fr(32'h0002_0000, 3'h0, 1'b0);
    nt(6);
    start_device_busy <= 1'b0;
    tk(18);
    apb(1'b1, 8'h00, 32'h0);
    fr(32'h0, 3'h1, 1'b1);
    tk(2);
    fr(32'h0, 3'h1, 1'b1);
    nt(4);
    ck({31'h0, halt}, 32'h1, "halt");
    apb(1'b1, 8'h34, 32'h2);
    ck({31'h0, halt}, 32'h0, "halt");
    apb(1'b1, 8'h00, 32'h0);
    fr(32'h0, 3'h2, 1'b1);
    tk(2);
    apb(1'b1, 8'h00, 32'h0);
    fr(32'h0, 3'h3, 1'b1);
    tk(2);
    apb(1'b1, 8'h00, 32'h0);
    fr(32'h0, 3'h4, 1'b1);
    nt(4);
    ck({31'h0, halt}, 32'h1, "halt");
    apb(1'b1, 8'h34, 32'h2);
    for (int k = 1; k <= 4; k++) begin
      fr(32'h0, 3'(k), 1'b0);
      nt(3);
    end
    ck({31'h0, halt}, 32'h0, "halt");
    apb(1'b1, 8'h30, 32'h3);
    apb(1'b1, 8'h34, 32'h1);
    nt(6);
    tk(17);
    rd(8'h30, 32'h0);
    apb(1'b1, 8'h34, 32'h0);
    final_report();
  end
  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge clock);
    fail("watchdog");
    final_report();
  end
endmodule : testbench
